/* bench/ltrb_host_model.sv */
// host side model: drives the register port strobes one transfer at a time
`timescale 1ns/1ps
module ltrb_host_model
    import ltrb_pkg::*;
(
    input  wire logic              i_clk,
    output logic      [ADDR_W-1:0] o_addr,
    output logic                   o_wr,
    output logic                   o_rd,
    output logic      [DATA_W-1:0] o_wdata,
    input  wire logic [DATA_W-1:0] i_rdata,
    input  wire logic              i_rvalid
);
    initial begin
        o_addr  = '0;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = '0;
    end

    // released lines show the inverse, so a stale value never passes for a live one
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic ok);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        ok = i_rvalid;
        d  = i_rdata;
    endtask : rd
endmodule : ltrb_host_model

/* bench/ltrb_limit_bank_test.sv */
// self-checking bench for the limit threshold register bank
`timescale 1ns/1ps
module ltrb_limit_bank_test;
    import ltrb_pkg::*;
    localparam logic [15:0] TB_MAKER = 16'h4D4B; // arbitrary value
    localparam logic [11:0] TB_PART  = 12'hA5C;  // arbitrary value
    localparam logic [3:0]  TB_REV   = 4'h3;     // arbitrary value
    typedef struct packed {logic [5:0] a; logic [15:0] w; logic [15:0] e;} ltrb_row_t;
    localparam ltrb_row_t ROWS [7] = '{
        '{OFF_BUS_OVER,  16'hFFFF, 16'h7FFF}, '{OFF_BUS_UNDER, 16'h8005, 16'h0005},
        '{OFF_TEMP_OVER, 16'h8000, 16'h8000}, '{OFF_PWR_OVER,  16'h1234, 16'h1234},
        '{OFF_MAKER,     16'h0000, TB_MAKER}, '{OFF_PART_REV,  16'hFFFF, {TB_PART, TB_REV}},
        '{6'h20,         16'hFFFF, 16'h0000}};
    logic        clk, rstn, wr, rd, rvalid, conv, rsel, orsel, latch;
    logic [5:0]  addr;
    logic [15:0] wdata, rdata, lo, lu, lt, lp;
    ltrb_meas_t  meas, omeas;
    ltrb_flags_t flags, f;
    int          n_fail, samples_checked;

    ltrb_limit_bank #(
        .MAKER_CODE(TB_MAKER), .PART_CODE(TB_PART), .REV_CODE(TB_REV)
    ) u_ltrb_limit_bank (
        .i_clk(clk), .i_rstn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
        .i_conv_done(conv), .i_meas(meas), .i_range_select_bit(rsel), .o_meas(omeas),
        .o_range_select_bit(orsel), .o_flags(flags));
    ltrb_host_model u_ltrb_host_model (
        .i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata),
        .i_rdata(rdata), .i_rvalid(rvalid));

    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        ok;
        u_ltrb_host_model.rd(a, d, ok);
        chk({ok, d}, {1'b1, e});
        // valid stands one cycle only, the data holds until the next read
        @(posedge clk);
        #1;
        chk({rvalid, rdata}, {1'b0, e});
    endtask : rdchk

    task automatic wrt(input logic [5:0] a, input logic [15:0] d);
        u_ltrb_host_model.wr(a, d);
        case (a)
            OFF_BUS_OVER:  lo = d & BUS_LIM_MASK;
            OFF_BUS_UNDER: lu = d & BUS_LIM_MASK;
            OFF_TEMP_OVER: lt = d;
            OFF_PWR_OVER:  lp = d;
            OFF_DIAG:      latch = d[15];
            default: ;
        endcase
    endtask : wrt

    task automatic rst_chk;
        @(posedge clk);
        rstn <= 1'b0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk({flags, orsel, rvalid, rdata}, '0);
        chk(omeas, '0);
        {lo, lu, lt, lp} = {RST_BUS_OVER, RST_BUS_UNDER, RST_TEMP_OVER, RST_PWR_OVER};
        latch = 1'b0;
        f = '0;
        rdchk(OFF_BUS_OVER, RST_BUS_OVER);
        rdchk(OFF_BUS_UNDER, RST_BUS_UNDER);
        rdchk(OFF_TEMP_OVER, RST_TEMP_OVER);
        rdchk(OFF_PWR_OVER, RST_PWR_OVER);
        chk(flags, 4'h0);
    endtask : rst_chk

    // expected flags come from the threshold copies kept here, not from the design
    task automatic cv(input logic [19:0] b, input logic [15:0] t, input logic [23:0] p,
                      input logic r);
        ltrb_flags_t e;
        e = {($signed(t) > $signed(lt)), (b > {lo[14:0], 4'h0}), (b < {lu[14:0], 4'h0}),
             (p > {lp, 8'h00})};
        f = latch ? (f | e) : e;
        @(posedge clk);
        meas <= {20'hFFFFD, b, t, p};
        rsel <= r;
        conv <= 1'b1;
        @(posedge clk);
        conv <= 1'b0;
        meas <= ~meas;
        #1;
        chk(flags, f);
        chk(omeas, {20'hFFFFD, b, t, p});
        chk(orsel, r);
    endtask : cv

    task automatic rd_diag;
        rdchk(OFF_DIAG, {latch, 7'h0, f.temp_high_flag, 2'b0, f.bus_high_flag,
                         f.bus_low_flag, f.power_high_flag, 2'b0});
        if (latch) f = '0;
        chk(flags, f);
    endtask : rd_diag

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {rstn, conv, rsel, meas, n_fail, samples_checked} = '0;
        rst_chk();
        foreach (ROWS[i]) begin
            wrt(ROWS[i].a, ROWS[i].w);
            rdchk(ROWS[i].a, ROWS[i].e);
        end
        cv(20'h7FFF0, 16'h0000, 24'h123400, 1'b0);
        cv(20'h7FFF1, 16'h8000, 24'h123401, 1'b1);
        cv(20'h0004F, 16'h7FFF, 24'h000000, 1'b0);
        cv(20'h00050, 16'h8001, 24'hFFFFFF, 1'b0);
        rd_diag();
        wrt(OFF_BUS_OVER, 16'h0000);
        cv(20'h00001, 16'h8000, 24'h0, 1'b0);
        wrt(OFF_DIAG, 16'h8000);
        cv(20'h00001, 16'h0000, 24'hFFFFFF, 1'b1);
        cv(20'h00000, 16'h8000, 24'h0, 1'b0);
        rd_diag();
        rd_diag();
        cv(20'h00000, 16'h8000, 24'h0, 1'b0);
        // a conversion in the clearing read cycle must survive the clear
        fork
            rdchk(OFF_DIAG, 16'h8008);
            begin
                f = '0;
                cv(20'h00000, 16'h0000, 24'h0, 1'b0);
            end
        join
        rst_chk();
        cv(20'h00000, 16'h0000, 24'hFFFF00, 1'b0);
        cv(20'h7FFF1, 16'h7FFF, 24'hFFFF01, 1'b1);
        tally_and_finish();
    end
endmodule : ltrb_limit_bank_test

/* hdl/ltrb_limit_bank.sv */
// limit threshold register bank with identification registers and limit comparators
`timescale 1ns/1ps
module ltrb_limit_bank
    import ltrb_pkg::*;
#(
    parameter logic [15:0]       MAKER_CODE = 16'h4142, // arbitrary value
    parameter logic [PART_W-1:0] PART_CODE  = 12'h123,  // arbitrary value
    parameter logic [REV_W-1:0]  REV_CODE   = 4'h0      // arbitrary value
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic [ADDR_W-1:0] i_reg_addr,
    input  wire logic              i_reg_wr,
    input  wire logic [DATA_W-1:0] i_reg_wdata,
    input  wire logic              i_reg_rd,
    output logic      [DATA_W-1:0] o_reg_rdata,
    output logic                   o_reg_rvalid,
    input  wire logic              i_conv_done,
    input  wire ltrb_meas_t        i_meas,
    input  wire logic              i_range_select_bit,
    output ltrb_meas_t             o_meas,
    output logic                   o_range_select_bit,
    output ltrb_flags_t            o_flags
);
    logic [DATA_W-1:0] bus_over_q,  bus_over_d;
    logic [DATA_W-1:0] bus_under_q, bus_under_d;
    logic [DATA_W-1:0] temp_over_q, temp_over_d;
    logic [DATA_W-1:0] pwr_over_q,  pwr_over_d;
    logic              latch_q,     latch_d;
    ltrb_flags_t       flags_q,     flags_d;
    ltrb_meas_t        meas_q;
    logic              range_q;
    logic [DATA_W-1:0] rdata_q,     rdata_d;
    logic              rvalid_q;

    // address decode
    wire logic wr_bus_over  = i_reg_wr && (i_reg_addr == OFF_BUS_OVER);
    wire logic wr_bus_under = i_reg_wr && (i_reg_addr == OFF_BUS_UNDER);
    wire logic wr_temp_over = i_reg_wr && (i_reg_addr == OFF_TEMP_OVER);
    wire logic wr_pwr_over  = i_reg_wr && (i_reg_addr == OFF_PWR_OVER);
    wire logic wr_diag      = i_reg_wr && (i_reg_addr == OFF_DIAG);
    wire logic rd_diag      = i_reg_rd && (i_reg_addr == OFF_DIAG);

    // reserved bit 15 never stored, so it cannot read back
    assign bus_over_d  = wr_bus_over  ? (i_reg_wdata & BUS_LIM_MASK) : bus_over_q;
    assign bus_under_d = wr_bus_under ? (i_reg_wdata & BUS_LIM_MASK) : bus_under_q;
    assign temp_over_d = wr_temp_over ? i_reg_wdata : temp_over_q;
    assign pwr_over_d  = wr_pwr_over  ? i_reg_wdata : pwr_over_q;
    // only the latch mode bit of the diagnostic word is writable
    assign latch_d     = wr_diag ? i_reg_wdata[BIT_LATCH] : latch_q;

    // comparators; thresholds widened to the result's step size
    wire logic [BUS_W-1:0] bus_over_ext =
        {1'b0, bus_over_q[BUS_LIM_MSB:0], {BUS_LIM_SHIFT{1'b0}}};
    wire logic [BUS_W-1:0] bus_under_ext =
        {1'b0, bus_under_q[BUS_LIM_MSB:0], {BUS_LIM_SHIFT{1'b0}}};
    wire logic [PWR_W-1:0] pwr_over_ext = {pwr_over_q, {PWR_LIM_SHIFT{1'b0}}};
    wire logic cmp_bus_high  = i_meas.bus > bus_over_ext;
    wire logic cmp_bus_low   = i_meas.bus < bus_under_ext;
    wire logic cmp_temp_high = i_meas.temp > $signed(temp_over_q);
    wire logic cmp_pwr_high  = i_meas.power > pwr_over_ext;
    wire ltrb_flags_t cmp = '{temp_high_flag:  cmp_temp_high,
                              bus_high_flag:   cmp_bus_high,
                              bus_low_flag:    cmp_bus_low,
                              power_high_flag: cmp_pwr_high};

    // latched: a new event in the read cycle survives the clear, set wins
    wire logic         clr_flags = rd_diag && latch_q;
    wire ltrb_flags_t  ev        = i_conv_done ? cmp : '0;
    wire ltrb_flags_t  kept      = clr_flags ? '0 : flags_q;
    // transparent mode follows each conversion, reads leave it alone
    assign flags_d = latch_q ? (kept | ev) : (i_conv_done ? cmp : flags_q);

    wire logic [DATA_W-1:0] diag_word =
        (DATA_W'(latch_q)                 << BIT_LATCH)
      | (DATA_W'(flags_q.temp_high_flag)  << BIT_TEMP_HIGH)
      | (DATA_W'(flags_q.bus_high_flag)   << BIT_BUS_HIGH)
      | (DATA_W'(flags_q.bus_low_flag)    << BIT_BUS_LOW)
      | (DATA_W'(flags_q.power_high_flag) << BIT_PWR_HIGH);
    wire logic [DATA_W-1:0] part_rev_word = {PART_CODE, REV_CODE};

    // read mux; unmapped offsets read zero
    always_comb begin
        case (i_reg_addr)
            OFF_DIAG:      rdata_d = diag_word;
            OFF_BUS_OVER:  rdata_d = bus_over_q & BUS_LIM_MASK;
            OFF_BUS_UNDER: rdata_d = bus_under_q & BUS_LIM_MASK;
            OFF_TEMP_OVER: rdata_d = temp_over_q;
            OFF_PWR_OVER:  rdata_d = pwr_over_q;
            OFF_MAKER:     rdata_d = MAKER_CODE;
            OFF_PART_REV:  rdata_d = part_rev_word;
            default:       rdata_d = '0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            bus_over_q  <= RST_BUS_OVER;
            bus_under_q <= RST_BUS_UNDER;
            temp_over_q <= RST_TEMP_OVER;
            pwr_over_q  <= RST_PWR_OVER;
            latch_q     <= 1'b0;
            flags_q     <= '0;
        end else begin
            bus_over_q  <= bus_over_d;
            bus_under_q <= bus_under_d;
            temp_over_q <= temp_over_d;
            pwr_over_q  <= pwr_over_d;
            latch_q     <= latch_d;
            flags_q     <= flags_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= i_reg_rd ? rdata_d : rdata_q;
            rvalid_q <= i_reg_rd;
        end
    end

    // result capture; formats fixed by the struct: signed 20-bit shunt,
    // unsigned 20-bit bus, signed 16-bit temperature
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            meas_q  <= '0;
            range_q <= 1'b0;
        end else if (i_conv_done) begin
            meas_q  <= i_meas;
            // shunt step size goes with the range in force at the conversion
            range_q <= i_range_select_bit;
        end
    end

    assign o_reg_rdata        = rdata_q;
    assign o_reg_rvalid       = rvalid_q;
    assign o_meas             = meas_q;
    assign o_range_select_bit = range_q;
    assign o_flags            = flags_q;

    // checks
    logic past_rst_q;
    always_ff @(posedge i_clk) begin
        past_rst_q <= !i_rstn;
    end

    sequence s_conv_with(logic c);
        i_conv_done && c;
    endsequence

    sequence s_latched_read;
        latch_q && rd_diag;
    endsequence

    property p_reset_values;
        @(posedge i_clk) (past_rst_q && i_rstn) |->
            (bus_over_q == 16'h7FFF && bus_under_q == 16'h0000
             && temp_over_q == 16'h7FFF && pwr_over_q == 16'hFFFF);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("threshold reset value wrong");

    property p_bus_rsvd;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_reg_rd && (i_reg_addr == 6'h0E || i_reg_addr == 6'h0F)) |=> !o_reg_rdata[15];
    endproperty
    a_bus_rsvd: assert property (p_bus_rsvd)
        else $error("bus threshold bit 15 read as one");

    property p_id_read;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_reg_rd && i_reg_addr == 6'h3F) |=>
                (o_reg_rvalid && o_reg_rdata[15:4] == PART_CODE && o_reg_rdata[3:0] == REV_CODE);
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("part and revision read wrong");

    property p_maker_read;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_reg_rd && i_reg_addr == 6'h3E) |=> (o_reg_rdata == MAKER_CODE);
    endproperty
    a_maker_read: assert property (p_maker_read)
        else $error("maker code read wrong");

    property p_bus_high;
        @(posedge i_clk) disable iff (!i_rstn)
            s_conv_with(i_meas.bus > {1'b0, bus_over_q[14:0], 4'h0}) |=> o_flags.bus_high_flag;
    endproperty
    a_bus_high: assert property (p_bus_high)
        else $error("bus high flag missed");

    property p_bus_low;
        @(posedge i_clk) disable iff (!i_rstn)
            s_conv_with(i_meas.bus < {1'b0, bus_under_q[14:0], 4'h0}) |=> o_flags.bus_low_flag;
    endproperty
    a_bus_low: assert property (p_bus_low)
        else $error("bus low flag missed");

    property p_temp_high;
        @(posedge i_clk) disable iff (!i_rstn)
            s_conv_with(i_meas.temp > $signed(temp_over_q)) |=> o_flags.temp_high_flag;
    endproperty
    a_temp_high: assert property (p_temp_high)
        else $error("temperature high flag missed");

    property p_pwr_high;
        @(posedge i_clk) disable iff (!i_rstn)
            s_conv_with(i_meas.power > {pwr_over_q, 8'h00}) |=> o_flags.power_high_flag;
    endproperty
    a_pwr_high: assert property (p_pwr_high)
        else $error("power high flag missed");

    property p_latched_clear;
        @(posedge i_clk) disable iff (!i_rstn)
            (s_latched_read and !i_conv_done) |=> (o_flags == '0);
    endproperty
    a_latched_clear: assert property (p_latched_clear)
        else $error("latched read did not clear flags");

    property p_no_conv_hold;
        @(posedge i_clk) disable iff (!i_rstn)
            (!i_conv_done && !clr_flags) |=> $stable(o_flags);
    endproperty
    a_no_conv_hold: assert property (p_no_conv_hold)
        else $error("flags changed without a conversion");

    property p_default_no_power;
        @(posedge i_clk) disable iff (!i_rstn)
            (pwr_over_q == 16'hFFFF && i_conv_done && i_meas.power <= 24'hFFFF00)
                |=> (!o_flags.power_high_flag || latch_q);
    endproperty
    a_default_no_power: assert property (p_default_no_power)
        else $error("over power raised at full threshold");

    property p_wr_mask;
        @(posedge i_clk) disable iff (!i_rstn)
            wr_bus_over |=> (bus_over_q == ($past(i_reg_wdata) & 16'h7FFF));
    endproperty
    a_wr_mask: assert property (p_wr_mask)
        else $error("bus over threshold write not masked");

    property p_under_mask;
        @(posedge i_clk) disable iff (!i_rstn)
            wr_bus_under |=> (bus_under_q == ($past(i_reg_wdata) & 16'h7FFF));
    endproperty
    a_under_mask: assert property (p_under_mask)
        else $error("bus under threshold write not masked");

    property p_temp_write;
        @(posedge i_clk) disable iff (!i_rstn)
            wr_temp_over |=> (temp_over_q == $past(i_reg_wdata));
    endproperty
    a_temp_write: assert property (p_temp_write)
        else $error("temperature threshold write lost");

    property p_pwr_write;
        @(posedge i_clk) disable iff (!i_rstn)
            wr_pwr_over |=> (pwr_over_q == $past(i_reg_wdata));
    endproperty
    a_pwr_write: assert property (p_pwr_write)
        else $error("power threshold write lost");

    // identification and unmapped offsets must leave every stored bit alone
    property p_ro_write;
        @(posedge i_clk) disable iff (!i_rstn)
            (i_reg_wr && !(wr_bus_over || wr_bus_under || wr_temp_over || wr_pwr_over || wr_diag))
                |=> ($stable(bus_over_q) && $stable(bus_under_q) && $stable(temp_over_q)
                     && $stable(pwr_over_q) && $stable(latch_q));
    endproperty
    a_ro_write: assert property (p_ro_write)
        else $error("write to read-only offset changed state");

    property p_meas_capture;
        @(posedge i_clk) disable iff (!i_rstn)
            i_conv_done |=> (o_meas == $past(i_meas)
                             && o_range_select_bit == $past(i_range_select_bit));
    endproperty
    a_meas_capture: assert property (p_meas_capture)
        else $error("conversion results not captured");

    property p_set_wins;
        @(posedge i_clk) disable iff (!i_rstn)
            s_conv_with(clr_flags) |=> (o_flags == $past(cmp));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost in clearing read");

    property p_transparent_follow;
        @(posedge i_clk) disable iff (!i_rstn)
            (!latch_q && i_conv_done) |=> (o_flags == $past(cmp));
    endproperty
    a_transparent_follow: assert property (p_transparent_follow)
        else $error("transparent flags did not follow conversion");
endmodule : ltrb_limit_bank

/* hdl/ltrb_pkg.sv */
// package: offsets, field layouts, reset values and result formats of the limit register bank
package ltrb_pkg;
    localparam int          ADDR_W        = 6;
    localparam int          DATA_W        = 16;
    localparam logic [5:0]  OFF_DIAG      = 6'h0B;
    localparam logic [5:0]  OFF_BUS_OVER  = 6'h0E;
    localparam logic [5:0]  OFF_BUS_UNDER = 6'h0F;
    localparam logic [5:0]  OFF_TEMP_OVER = 6'h10;
    localparam logic [5:0]  OFF_PWR_OVER  = 6'h11;
    localparam logic [5:0]  OFF_MAKER     = 6'h3E;
    localparam logic [5:0]  OFF_PART_REV  = 6'h3F;
    localparam logic [15:0] RST_BUS_OVER  = 16'h7FFF;
    localparam logic [15:0] RST_BUS_UNDER = 16'h0000;
    localparam logic [15:0] RST_TEMP_OVER = 16'h7FFF;
    localparam logic [15:0] RST_PWR_OVER  = 16'hFFFF;
    localparam logic [15:0] BUS_LIM_MASK  = 16'h7FFF;
    localparam int          BUS_LIM_MSB   = 14;
    localparam int          BIT_TEMP_HIGH = 7;
    localparam int          BIT_BUS_HIGH  = 4;
    localparam int          BIT_BUS_LOW   = 3;
    localparam int          BIT_PWR_HIGH  = 2;
    localparam int          BIT_LATCH     = 15;
    localparam int          PART_LSB      = 4;
    localparam int          REV_W         = 4;
    localparam int          PART_W        = 12;
    // bus limit step 3.125 mV over bus result step 195.3125 uV is 16, i.e. 4 bits
    localparam int          BUS_LIM_SHIFT = 4;
    // power limit step is 256 power result steps
    localparam int          PWR_LIM_SHIFT = 8;
    localparam int          SHUNT_W       = 20;
    localparam int          BUS_W         = 20;
    localparam int          TEMP_W        = 16;
    localparam int          PWR_W         = 24;
    // result scaling per step, in the unit that ends each name
    localparam real         SHUNT_LSB_R0_NV = 312.5;
    localparam real         SHUNT_LSB_R1_NV = 78.125;
    localparam real         BUS_LSB_UV      = 195.3125;
    localparam real         TEMP_LSB_MC     = 7.8125;
    localparam real         BUS_LIM_LSB_MV  = 3.125;

    typedef struct packed {
        logic signed [SHUNT_W-1:0] shunt;
        logic        [BUS_W-1:0]   bus;
        logic signed [TEMP_W-1:0]  temp;
        logic        [PWR_W-1:0]   power;
    } ltrb_meas_t;

    typedef struct packed {
        logic temp_high_flag;
        logic bus_high_flag;
        logic bus_low_flag;
        logic power_high_flag;
    } ltrb_flags_t;
endpackage : ltrb_pkg
